// File: duc_top.sv
// dual channel configuration, status and output port logic
// Function
// - parity mode field selects with/force/none/multidrop
// - receive interrupt source: has-data or queue-full
// - error mode: per-character or accumulated block
// - block errors held until error reset or receiver reset
// - channel mode: normal, echo, local, remote loop
// - end-bit code picks length in sixteenths
// - five-bit characters add half bit, codes 0-7
// - transmit data ignored while transmitter disabled
// - error flags stored with each received character
// - status: queue-top flags plus live flags
// - error reset clears queue-held error flags
// - per-character flags dropped when character read
// - config bits 7,6 pick latch or transmit-ready
// - config bits 5,4 pick latch or receive flag
// - config 3:2 picks latch, timer, B clocks
// - config 1:0 picks latch or A clocks
// - latch-driven pins show inverted latch bit
// - mode pointer: first after reset, then second
// - flow control negates request-to-send when a start bit arrives while full
`timescale 1ns/1ps
module duc_top
  import duc_pkg::*;
#(
  parameter int FIFO_DEPTH = DUC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // parallel register port pins
  input wire logic [3:0] ADDR,
  input wire logic CHIP_EN_N,
  input wire logic READ_N,
  input wire logic WRITE_N,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_N,
  // receiver character side, index 0 channel A, 1 channel B
  input wire logic [1:0] RX_PUSH,
  input wire logic [1:0][7:0] RX_DATA,
  input wire logic [1:0] RX_BREAK,
  input wire logic [1:0] RX_FRAMING,
  input wire logic [1:0] RX_PARITY,
  input wire logic [1:0] RX_START,
  input wire logic [1:0] RX_OVERRUN,
  // transmitter side
  input wire logic [1:0] TX_READY_IN,
  input wire logic [1:0] TX_DRAINED_IN,
  output logic [1:0] TX_LOAD,
  output logic [1:0][7:0] TX_DATA,
  // channel configuration to the serializers
  output logic [1:0][1:0] PARITY_MODE,
  output logic [1:0] PARITY_ODD,
  output logic [1:0][3:0] CHAR_BITS,
  output logic [1:0][1:0] CHANNEL_MODE,
  output logic [1:0][5:0] STOP_SIXTEENTHS,
  output logic [1:0][3:0] RX_CLOCK_SELECT,
  output logic [1:0][3:0] TX_CLOCK_SELECT,
  output logic [1:0] RX_ENABLED,
  output logic [1:0] TX_ENABLED,
  output logic [1:0] RX_INT_SOURCE,
  // clock and timer sources for the output port
  input wire logic CT_OUT,
  input wire logic CHAN_A_TX_CLK16,
  input wire logic CHAN_A_TX_CLK1,
  input wire logic CHAN_A_RX_CLK1,
  input wire logic CHAN_B_TX_CLK1,
  input wire logic CHAN_B_RX_CLK1,
  // general output port
  output logic [7:0] GENERAL_OUTPUT_PIN
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [14:0] pin_meta_q, pin_sync_q;
  logic rd_prev_q, wr_prev_q;
  logic [3:0] a_s;
  logic [7:0] d_s;
  logic rd_act, wr_act, rd_start, wr_start;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pin_meta_q <= 15'h7000;
      pin_sync_q <= 15'h7000;
    end else begin
      pin_meta_q <= {CHIP_EN_N, READ_N, WRITE_N, ADDR, DATA_IN};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign a_s = pin_sync_q[11:8];
  assign d_s = pin_sync_q[7:0];
  assign rd_act = !pin_sync_q[14] && !pin_sync_q[13];
  assign wr_act = !pin_sync_q[14] && !pin_sync_q[12] && !rd_act;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
    end
  end

  // one action per strobe assertion
  assign rd_start = rd_act && !rd_prev_q;
  assign wr_start = wr_act && !wr_prev_q;

  // ****************************************
  // address decode
  // ****************************************
  logic [1:0] wr_mode, rd_mode, wr_csr, wr_cmd, wr_thr, rd_rhr;
  logic wr_pin_cfg, wr_set, wr_clr;

  assign wr_mode = {wr_start && a_s == DUC_ADDR_MODE_B, wr_start && a_s == DUC_ADDR_MODE_A};
  assign rd_mode = {rd_start && a_s == DUC_ADDR_MODE_B, rd_start && a_s == DUC_ADDR_MODE_A};
  assign wr_csr = {wr_start && a_s == DUC_ADDR_STAT_B, wr_start && a_s == DUC_ADDR_STAT_A};
  assign wr_cmd = {wr_start && a_s == DUC_ADDR_CMD_B, wr_start && a_s == DUC_ADDR_CMD_A};
  assign wr_thr = {wr_start && a_s == DUC_ADDR_DATA_B, wr_start && a_s == DUC_ADDR_DATA_A};
  assign rd_rhr = {rd_start && a_s == DUC_ADDR_DATA_B, rd_start && a_s == DUC_ADDR_DATA_A};
  assign wr_pin_cfg = wr_start && a_s == DUC_ADDR_PIN_CFG;
  assign wr_set = wr_start && a_s == DUC_ADDR_SET;
  assign wr_clr = wr_start && a_s == DUC_ADDR_CLR;

  // ****************************************
  // channels
  // ****************************************
  logic [1:0][7:0] mode_rdata, status, rhr, mr1, mr2, csr;
  logic [1:0][5:0] stop_len;
  logic [1:0] rx_en, tx_en, tx_load, rx_int, tx_rdy, rts_neg;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    duc_chan #(
      .DEPTH(FIFO_DEPTH)
    ) u_chan (
      .clk(CLK),
      .rst_n(RST_B),
      .wr_mode(wr_mode[c]),
      .rd_mode(rd_mode[c]),
      .wr_csr(wr_csr[c]),
      .wr_cmd(wr_cmd[c]),
      .wr_thr(wr_thr[c]),
      .rd_rhr(rd_rhr[c]),
      .wdata(d_s),
      .rx_push(RX_PUSH[c]),
      .rx_data(RX_DATA[c]),
      .rx_err({RX_BREAK[c], RX_FRAMING[c], RX_PARITY[c]}),
      .rx_start(RX_START[c]),
      .rx_ovr(RX_OVERRUN[c]),
      .tx_rdy_in(TX_READY_IN[c]),
      .tx_emt_in(TX_DRAINED_IN[c]),
      .tx_load(tx_load[c]),
      .mode_rdata(mode_rdata[c]),
      .status(status[c]),
      .rhr(rhr[c]),
      .mr1(mr1[c]),
      .mr2(mr2[c]),
      .csr(csr[c]),
      .rx_en(rx_en[c]),
      .tx_en(tx_en[c]),
      .stop_len(stop_len[c]),
      .rx_int(rx_int[c]),
      .tx_rdy(tx_rdy[c]),
      .rts_neg(rts_neg[c])
    );
  end

  // ****************************************
  // configuration outputs
  // ****************************************
  always_ff @(posedge CLK) begin
    for (int c = 0; c < 2; c++) begin
      if (!RST_B) begin
        PARITY_MODE[c] <= DUC_PAR_WITH;
        PARITY_ODD[c] <= 1'b0;
        CHAR_BITS[c] <= 4'h5;
        CHANNEL_MODE[c] <= DUC_CM_NORMAL;
        STOP_SIXTEENTHS[c] <= DUC_STOP_SHORT_BASE + DUC_STOP_FIVE_EXTRA;
        RX_CLOCK_SELECT[c] <= 4'h0;
        TX_CLOCK_SELECT[c] <= 4'h0;
        RX_ENABLED[c] <= 1'b0;
        TX_ENABLED[c] <= 1'b0;
        RX_INT_SOURCE[c] <= 1'b0;
      end else begin
        PARITY_MODE[c] <= mr1[c][4:3];
        PARITY_ODD[c] <= mr1[c][DUC_MR1_PTYPE];
        CHAR_BITS[c] <= 4'h5 + {2'b00, mr1[c][1:0]};
        CHANNEL_MODE[c] <= mr2[c][7:6];
        STOP_SIXTEENTHS[c] <= stop_len[c];
        RX_CLOCK_SELECT[c] <= csr[c][7:4];
        TX_CLOCK_SELECT[c] <= csr[c][3:0];
        RX_ENABLED[c] <= rx_en[c];
        TX_ENABLED[c] <= tx_en[c];
        RX_INT_SOURCE[c] <= rx_int[c];
      end
    end
  end

  // ****************************************
  // transmit holding data
  // ****************************************
  always_ff @(posedge CLK) begin
    for (int c = 0; c < 2; c++) begin
      if (!RST_B) begin
        TX_LOAD[c] <= 1'b0;
        TX_DATA[c] <= 8'h00;
      end else begin
        TX_LOAD[c] <= tx_load[c];
        if (tx_load[c]) TX_DATA[c] <= d_s;
      end
    end
  end

  // ****************************************
  // read data path
  // ****************************************
  logic [7:0] rdata;

  always_comb begin
    case (a_s)
      DUC_ADDR_MODE_A: rdata = mode_rdata[0];
      DUC_ADDR_STAT_A: rdata = status[0];
      DUC_ADDR_DATA_A: rdata = rhr[0];
      DUC_ADDR_MODE_B: rdata = mode_rdata[1];
      DUC_ADDR_STAT_B: rdata = status[1];
      DUC_ADDR_DATA_B: rdata = rhr[1];
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      DATA_OUT <= 8'h00;
      DATA_OE_N <= 1'b1;
    end else begin
      // sampled at read start, before the queue pops
      if (rd_start) DATA_OUT <= rdata;
      // bus released three edges after the strobe rises
      DATA_OE_N <= !rd_act;
    end
  end

  // ****************************************
  // output port configuration and latch
  // ****************************************
  logic [7:0] pin_cfg_q, latch_q, pin_d;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pin_cfg_q <= DUC_REG_RESET;
      latch_q <= DUC_REG_RESET;
    end else begin
      if (wr_pin_cfg) pin_cfg_q <= d_s;
      // set and clear addresses never coincide
      if (wr_set) latch_q <= latch_q | d_s;
      else if (wr_clr) latch_q <= latch_q & ~d_s;
    end
  end

  // ****************************************
  // output pin selection
  // ****************************************
  always_comb begin
    // flow-control negation forces request-to-send high
    pin_d[0] = !latch_q[0] || rts_neg[0];
    pin_d[1] = !latch_q[1] || rts_neg[1];
    case (pin_cfg_q[1:0])
      2'b00: pin_d[2] = !latch_q[2];
      2'b01: pin_d[2] = CHAN_A_TX_CLK16;
      2'b10: pin_d[2] = CHAN_A_TX_CLK1;
      default: pin_d[2] = CHAN_A_RX_CLK1;
    endcase
    case (pin_cfg_q[3:2])
      2'b00: pin_d[3] = !latch_q[3];
      2'b01: pin_d[3] = CT_OUT;
      2'b10: pin_d[3] = CHAN_B_TX_CLK1;
      default: pin_d[3] = CHAN_B_RX_CLK1;
    endcase
    // status outputs are active low like the latch pins
    pin_d[4] = pin_cfg_q[4] ? !rx_int[0] : !latch_q[4];
    pin_d[5] = pin_cfg_q[5] ? !rx_int[1] : !latch_q[5];
    pin_d[6] = pin_cfg_q[6] ? !tx_rdy[0] : !latch_q[6];
    pin_d[7] = pin_cfg_q[7] ? !tx_rdy[1] : !latch_q[7];
  end

  // ****************************************
  // registered output port
  // ****************************************
  // selected clocks reach the pins one flop late
  always_ff @(posedge CLK) begin
    if (!RST_B) GENERAL_OUTPUT_PIN <= 8'hff;
    else GENERAL_OUTPUT_PIN <= pin_d;
  end

endmodule : duc_top

// File: duc_pkg.sv
// shared constants and types for the dual channel configuration block
package duc_pkg;

  // ****************************************
  // register port addresses
  // ****************************************
  localparam logic [3:0] DUC_ADDR_MODE_A = 4'h0;
  localparam logic [3:0] DUC_ADDR_STAT_A = 4'h1;
  localparam logic [3:0] DUC_ADDR_CMD_A = 4'h2;
  localparam logic [3:0] DUC_ADDR_DATA_A = 4'h3;
  localparam logic [3:0] DUC_ADDR_MODE_B = 4'h8;
  localparam logic [3:0] DUC_ADDR_STAT_B = 4'h9;
  localparam logic [3:0] DUC_ADDR_CMD_B = 4'ha;
  localparam logic [3:0] DUC_ADDR_DATA_B = 4'hb;
  localparam logic [3:0] DUC_ADDR_PIN_CFG = 4'hd;
  localparam logic [3:0] DUC_ADDR_SET = 4'he;
  localparam logic [3:0] DUC_ADDR_CLR = 4'hf;

  // ****************************************
  // field positions
  // ****************************************
  localparam int DUC_MR1_RTS = 7;
  localparam int DUC_MR1_RXINT = 6;
  localparam int DUC_MR1_ERRMODE = 5;
  localparam int DUC_MR1_PTYPE = 2;
  localparam int DUC_CMD_DIS_TX = 3;
  localparam int DUC_CMD_EN_TX = 2;
  localparam int DUC_CMD_DIS_RX = 1;
  localparam int DUC_CMD_EN_RX = 0;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [7:0] DUC_REG_RESET = 8'h00;
  localparam int DUC_FIFO_DEPTH = 4;
  localparam logic [5:0] DUC_STOP_SHORT_BASE = 6'h09;
  localparam logic [5:0] DUC_STOP_LONG_BASE = 6'h11;
  localparam logic [5:0] DUC_STOP_FIVE_EXTRA = 6'h08;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    DUC_PAR_WITH = 2'b00, DUC_PAR_FORCE = 2'b01, DUC_PAR_NONE = 2'b10, DUC_PAR_MDROP = 2'b11
  } duc_par_t;
  typedef enum logic [1:0] {
    DUC_LEN_5 = 2'b00, DUC_LEN_6 = 2'b01, DUC_LEN_7 = 2'b10, DUC_LEN_8 = 2'b11
  } duc_len_t;
  typedef enum logic [1:0] {
    DUC_CM_NORMAL = 2'b00, DUC_CM_ECHO = 2'b01, DUC_CM_LOCAL = 2'b10, DUC_CM_REMOTE = 2'b11
  } duc_cmode_t;
  typedef enum logic [2:0] {
    DUC_CMD_NOP = 3'b000, DUC_CMD_PTR_RST = 3'b001, DUC_CMD_RX_RST = 3'b010,
    DUC_CMD_TX_RST = 3'b011, DUC_CMD_ERR_RST = 3'b100
  } duc_cmd_t;

endpackage : duc_pkg

// File: duc_chan.sv
// one serial channel: mode registers, command, receive status queue
`timescale 1ns/1ps
module duc_chan
  import duc_pkg::*;
#(
  parameter int DEPTH = DUC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register strobes
  input wire logic wr_mode,
  input wire logic rd_mode,
  input wire logic wr_csr,
  input wire logic wr_cmd,
  input wire logic wr_thr,
  input wire logic rd_rhr,
  input wire logic [7:0] wdata,
  // receiver character side
  input wire logic rx_push,
  input wire logic [7:0] rx_data,
  input wire logic [2:0] rx_err,
  input wire logic rx_start,
  input wire logic rx_ovr,
  // transmitter side
  input wire logic tx_rdy_in,
  input wire logic tx_emt_in,
  output logic tx_load,
  // register views
  output logic [7:0] mode_rdata,
  output logic [7:0] status,
  output logic [7:0] rhr,
  output logic [7:0] mr1,
  output logic [7:0] mr2,
  output logic [7:0] csr,
  // derived controls
  output logic rx_en,
  output logic tx_en,
  output logic [5:0] stop_len,
  output logic rx_int,
  output logic tx_rdy,
  output logic rts_neg
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [7:0] data_mem [DEPTH];
  logic [2:0] err_mem [DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [CW-1:0] cnt_q;
  logic ptr_q, ovr_q;
  logic [2:0] accum_q, top_err;
  logic full, empty, push, pop, err_rst, rx_rst, tx_rst, ptr_rst;
  duc_cmd_t cmd;

  assign cmd = duc_cmd_t'(wdata[6:4]); // top bit ignored
  assign err_rst = wr_cmd && cmd == DUC_CMD_ERR_RST;
  assign rx_rst = wr_cmd && cmd == DUC_CMD_RX_RST;
  assign tx_rst = wr_cmd && cmd == DUC_CMD_TX_RST;
  assign ptr_rst = wr_cmd && cmd == DUC_CMD_PTR_RST;
  assign full = cnt_q == CW'(DEPTH);
  assign empty = cnt_q == '0;
  // multidrop: disabled receiver still takes address-tagged characters
  assign push = rx_push && !full && (rx_en || (mr1[4:3] == DUC_PAR_MDROP && rx_err[0]));
  assign pop = rd_rhr && !empty;
  assign rhr = data_mem[rd_ptr_q];
  assign top_err = empty ? 3'b000 : err_mem[rd_ptr_q];
  assign mode_rdata = ptr_q ? mr2 : mr1;
  assign tx_load = wr_thr && tx_en;
  assign tx_rdy = tx_en && tx_rdy_in && mr2[7:6] != DUC_CM_ECHO;
  assign rx_int = mr1[DUC_MR1_RXINT] ? full : !empty;
  assign status = {(mr1[DUC_MR1_ERRMODE] ? (accum_q | top_err) : top_err),
                   ovr_q, tx_en && tx_emt_in && mr2[7:6] != DUC_CM_ECHO, tx_rdy, full, !empty};
  assign stop_len = mr2[3] ? DUC_STOP_LONG_BASE + {2'b00, mr2[3:0]}
                  : DUC_STOP_SHORT_BASE + {2'b00, mr2[3:0]}
                    + ((mr1[1:0] == DUC_LEN_5) ? DUC_STOP_FIVE_EXTRA : 6'h00);

  always_ff @(posedge clk) begin
    if (!rst_n || ptr_rst) begin
      ptr_q <= 1'b0;
    end else if (wr_mode || rd_mode) begin
      ptr_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mr1 <= DUC_REG_RESET;
      mr2 <= DUC_REG_RESET;
      csr <= DUC_REG_RESET;
    end else begin
      if (wr_mode && !ptr_q) mr1 <= wdata;
      if (wr_mode && ptr_q) mr2 <= wdata;
      if (wr_csr) csr <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_en <= 1'b0;
      tx_en <= 1'b0;
    end else if (wr_cmd) begin
      if (wdata[DUC_CMD_DIS_RX] || rx_rst) rx_en <= 1'b0;
      else if (wdata[DUC_CMD_EN_RX]) rx_en <= 1'b1;
      if (wdata[DUC_CMD_DIS_TX] || tx_rst) tx_en <= 1'b0;
      else if (wdata[DUC_CMD_EN_TX]) tx_en <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || rx_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (push && wr_ptr_q == PW'(i)) begin
        data_mem[i] <= rx_data;
        err_mem[i] <= rx_err;
      end else if (!rst_n || err_rst || (rx_rst && rd_ptr_q == PW'(i))) begin
        err_mem[i] <= 3'b000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || err_rst || rx_rst) accum_q <= 3'b000;
    else accum_q <= accum_q | top_err;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) ovr_q <= 1'b0;
    else ovr_q <= rx_ovr || (ovr_q && !err_rst && !rx_rst);
  end

  always_ff @(posedge clk) begin
    if (!rst_n || rx_rst) rts_neg <= 1'b0;
    else if (mr1[DUC_MR1_RTS] && rx_start && full) rts_neg <= 1'b1;
    else if (!full) rts_neg <= 1'b0;
  end

endmodule : duc_chan

// File: duc_chk.sv
// port checker for the dual channel configuration block
`timescale 1ns/1ps
module duc_chk
  import duc_pkg::*;
#(
  parameter int FIFO_DEPTH = DUC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic CHIP_EN_N,
  input wire logic READ_N,
  input wire logic WRITE_N,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE_N,
  // channel outputs
  input wire logic [1:0] TX_LOAD,
  input wire logic [1:0][1:0] PARITY_MODE,
  input wire logic [1:0][3:0] CHAR_BITS,
  input wire logic [1:0][5:0] STOP_SIXTEENTHS,
  input wire logic [1:0] RX_ENABLED,
  input wire logic [1:0] TX_ENABLED
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  property p_oe_start;
    $fell(DATA_OE_N) |-> $past(!READ_N && !CHIP_EN_N, 2);
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("bus driven without read");
  property p_oe_hold;
    !DATA_OE_N |-> !$past(READ_N) || !$past(READ_N, 2) || !$past(READ_N, 3);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("bus driven too long");
  property p_dout;
    !$stable(DATA_OUT) |-> $past(!READ_N, 2);
  endproperty
  a_dout: assert property (p_dout) else $error("read data moved outside a read");
  property p_load_en;
    TX_LOAD[0] |-> TX_ENABLED[0];
  endproperty
  a_load_en: assert property (p_load_en) else $error("load while disabled");
  property p_load_src;
    TX_LOAD[0] |-> ($past(ADDR) == DUC_ADDR_DATA_A && !$past(WRITE_N)) ##1 !TX_LOAD[0];
  endproperty
  a_load_src: assert property (p_load_src) else $error("load without data write");
  property p_stop;
    CHAR_BITS[1] == 4'h5 ? STOP_SIXTEENTHS[1] inside {[6'h11:6'h20]}
      : STOP_SIXTEENTHS[1] inside {[6'h09:6'h10], [6'h19:6'h20]};
  endproperty
  a_stop: assert property (p_stop) else $error("end length out of range");
  property p_rx_on;
    $rose(RX_ENABLED[0]) |-> $past(ADDR) == DUC_ADDR_CMD_A && !$past(WRITE_N);
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("receiver on without command");
  property p_tx_off;
    $fell(TX_ENABLED[0]) |-> $past(ADDR) == DUC_ADDR_CMD_A && !$past(WRITE_N);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmitter off without command");
  property p_par;
    $changed(PARITY_MODE[1]) |-> $past(ADDR) == DUC_ADDR_MODE_B && !$past(WRITE_N);
  endproperty
  a_par: assert property (p_par) else $error("parity mode moved without write");
  c_read: cover property ($fell(DATA_OE_N));
  c_load: cover property (TX_LOAD[0]);
  c_rx_on: cover property ($rose(RX_ENABLED[0]));
endmodule : duc_chk

bind duc_top duc_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_duc_chk (.CLK(CLK), .RST_B(RST_B),
  .ADDR(ADDR), .CHIP_EN_N(CHIP_EN_N), .READ_N(READ_N), .WRITE_N(WRITE_N),
  .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .TX_LOAD(TX_LOAD), .PARITY_MODE(PARITY_MODE),
  .CHAR_BITS(CHAR_BITS), .STOP_SIXTEENTHS(STOP_SIXTEENTHS), .RX_ENABLED(RX_ENABLED),
  .TX_ENABLED(TX_ENABLED));

// File: duc_remote.sv
// remote serial device model: received characters and transmitter levels
`timescale 1ns/1ps
module duc_remote (
  // clock
  input wire logic clk,
  // received character side
  output logic [1:0] push,
  output logic [1:0][7:0] data,
  output logic [1:0] brk,
  output logic [1:0] frm,
  output logic [1:0] par,
  output logic [1:0] start,
  output logic [1:0] ovr,
  // transmitter levels
  output logic [1:0] tx_rdy,
  output logic [1:0] tx_emt
);
  initial begin
    push = 2'h0;
    data = 16'h0000;
    {brk, frm, par} = 6'h00;
    {start, ovr} = 4'h0;
    tx_rdy = 2'h3;
    tx_emt = 2'h3;
  end
  // start bit, then the character; a lost one only shows overrun
  task automatic send(input int ch, input logic [7:0] d, input logic [2:0] e, input logic lost);
    @(posedge clk);
    start[ch] <= 1'b1;
    ovr[ch] <= lost;
    @(posedge clk);
    start[ch] <= 1'b0;
    ovr[ch] <= 1'b0;
    push[ch] <= !lost;
    data[ch] <= d;
    {brk[ch], frm[ch], par[ch]} <= e;
    @(posedge clk);
    push[ch] <= 1'b0;
    data[ch] <= ~d;
    {brk[ch], frm[ch], par[ch]} <= ~e;
    repeat (3) @(posedge clk);
  endtask : send
  task automatic set_tx(input logic [1:0] r);
    @(posedge clk);
    tx_rdy <= r;
    repeat (3) @(posedge clk);
  endtask : set_tx
endmodule : duc_remote

// File: duc_tb_top.sv
// self-checking bench for the dual channel configuration block
`timescale 1ns/1ps
module duc_tb_top
  import duc_pkg::*;
;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic CHIP_EN_N = 1'b1;
  logic READ_N = 1'b1;
  logic WRITE_N = 1'b1;
  logic [7:0] DATA_IN = 8'h00;
  logic [7:0] DATA_OUT, GENERAL_OUTPUT_PIN, q;
  logic DATA_OE_N;
  logic [1:0] RX_PUSH, RX_BREAK, RX_FRAMING, RX_PARITY, RX_START, RX_OVERRUN, RX_INT_SOURCE;
  logic [1:0] TX_READY_IN, TX_DRAINED_IN, TX_LOAD, PARITY_ODD, RX_ENABLED, TX_ENABLED;
  logic [1:0][7:0] RX_DATA, TX_DATA;
  logic [1:0][1:0] PARITY_MODE, CHANNEL_MODE;
  logic [1:0][3:0] CHAR_BITS, RX_CLOCK_SELECT, TX_CLOCK_SELECT;
  logic [1:0][5:0] STOP_SIXTEENTHS;
  logic [2:0] src = 3'h0;
  logic [3:0] codes [4] = '{4'h7, 4'h3, 4'h8, 4'hf};
  int mismatches = 0;
  int cmp_count = 0;
  int loads = 0;
  initial begin
    forever #5 CLK = ~CLK;
  end
  duc_top #(.FIFO_DEPTH(4)) u_duc_top (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
    .CHIP_EN_N(CHIP_EN_N), .READ_N(READ_N), .WRITE_N(WRITE_N), .DATA_IN(DATA_IN),
    .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .RX_PUSH(RX_PUSH), .RX_DATA(RX_DATA),
    .RX_BREAK(RX_BREAK), .RX_FRAMING(RX_FRAMING), .RX_PARITY(RX_PARITY), .RX_START(RX_START),
    .RX_OVERRUN(RX_OVERRUN), .TX_READY_IN(TX_READY_IN), .TX_DRAINED_IN(TX_DRAINED_IN),
    .TX_LOAD(TX_LOAD), .TX_DATA(TX_DATA), .PARITY_MODE(PARITY_MODE), .PARITY_ODD(PARITY_ODD),
    .CHAR_BITS(CHAR_BITS), .CHANNEL_MODE(CHANNEL_MODE), .STOP_SIXTEENTHS(STOP_SIXTEENTHS),
    .RX_CLOCK_SELECT(RX_CLOCK_SELECT), .TX_CLOCK_SELECT(TX_CLOCK_SELECT),
    .RX_ENABLED(RX_ENABLED), .TX_ENABLED(TX_ENABLED), .RX_INT_SOURCE(RX_INT_SOURCE),
    .CT_OUT(src[0]),
    .CHAN_A_TX_CLK16(src[0]), .CHAN_A_TX_CLK1(src[1]), .CHAN_A_RX_CLK1(src[2]),
    .CHAN_B_TX_CLK1(src[1]), .CHAN_B_RX_CLK1(src[2]), .GENERAL_OUTPUT_PIN(GENERAL_OUTPUT_PIN));
  duc_remote u_duc_remote (.clk(CLK), .push(RX_PUSH), .data(RX_DATA), .brk(RX_BREAK),
    .frm(RX_FRAMING), .par(RX_PARITY), .start(RX_START), .ovr(RX_OVERRUN),
    .tx_rdy(TX_READY_IN), .tx_emt(TX_DRAINED_IN));
  always @(posedge CLK) begin
    if (TX_LOAD[0] === 1'b1)
      loads <= loads + 1;
  end
  // ****
  // access tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // strobe held five cycles, then high four
  task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic rd_op);
    ADDR <= a;
    DATA_IN <= d;
    CHIP_EN_N <= 1'b0;
    READ_N <= !rd_op;
    WRITE_N <= rd_op;
    repeat (4) @(posedge CLK);
    #1 q = DATA_OUT;
    @(posedge CLK);
    {CHIP_EN_N, READ_N, WRITE_N} <= 3'h7;
    repeat (4) @(posedge CLK);
  endtask : acc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(a, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    acc(a, 8'h00, 1'b1);
    chk(q & m, e);
  endtask : rd
  function automatic logic [7:0] stop_exp(input logic five, input logic [3:0] c);
    return 8'(c < 4'h8 ? 6'h09 + c + (five ? 6'h08 : 6'h00) : 6'h11 + c);
  endfunction : stop_exp
  task automatic complete_run;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    complete_run();
  end
  // ****
  // tests
  // ****
  initial begin
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (4) @(posedge CLK);
    chk({4'h0, CHAR_BITS[0]}, 8'h05);
    chk({2'h0, STOP_SIXTEENTHS[0]}, 8'h11);
    chk(GENERAL_OUTPUT_PIN, 8'hff);
    rd(4'hc, 8'hff, 8'h00);
    wr(DUC_ADDR_MODE_A, 8'h13);
    wr(DUC_ADDR_MODE_A, 8'h07);
    wr(DUC_ADDR_CMD_A, 8'h10);
    rd(DUC_ADDR_MODE_A, 8'hff, 8'h13);
    rd(DUC_ADDR_MODE_A, 8'hff, 8'h07);
    for (int i = 0; i < 4; i++) begin
      wr(DUC_ADDR_CMD_B, 8'h10);
      wr(DUC_ADDR_MODE_B, {3'h0, 2'(i), i[0], 2'(i)});
      wr(DUC_ADDR_MODE_B, {2'(i), 2'h0, codes[i]});
      wr(DUC_ADDR_STAT_B, {4'(i), ~4'(i)});
      chk({6'h0, PARITY_MODE[1]}, 8'(i));
      chk({7'h0, PARITY_ODD[1]}, {7'h0, i[0]});
      chk({4'h0, CHAR_BITS[1]}, 8'(5 + i));
      chk({6'h0, CHANNEL_MODE[1]}, 8'(i));
      chk({2'h0, STOP_SIXTEENTHS[1]}, stop_exp(i == 0, codes[i]));
      chk({RX_CLOCK_SELECT[1], TX_CLOCK_SELECT[1]}, {4'(i), ~4'(i)});
      rd(DUC_ADDR_MODE_B, 8'hff, {2'(i), 2'h0, codes[i]});
    end
    u_duc_remote.send(1, 8'h55, 3'b001, 1'b0);
    u_duc_remote.send(1, 8'h66, 3'b000, 1'b0);
    rd(DUC_ADDR_STAT_B, 8'h21, 8'h21);
    rd(DUC_ADDR_DATA_B, 8'hff, 8'h55);
    rd(DUC_ADDR_STAT_B, 8'h01, 8'h00);
    wr(DUC_ADDR_DATA_A, 8'h5a);
    chk(8'(loads), 8'h00);
    wr(DUC_ADDR_CMD_A, 8'h05);
    chk({6'h0, RX_ENABLED[0], TX_ENABLED[0]}, 8'h03);
    wr(DUC_ADDR_DATA_A, 8'ha5);
    chk(8'(loads), 8'h01);
    chk(TX_DATA[0], 8'ha5);
    u_duc_remote.send(0, 8'h41, 3'b010, 1'b0);
    u_duc_remote.send(0, 8'h42, 3'b000, 1'b0);
    rd(DUC_ADDR_STAT_A, 8'he1, 8'h41);
    rd(DUC_ADDR_DATA_A, 8'hff, 8'h41);
    rd(DUC_ADDR_STAT_A, 8'he1, 8'h01);
    rd(DUC_ADDR_DATA_A, 8'hff, 8'h42);
    wr(DUC_ADDR_PIN_CFG, 8'h10);
    u_duc_remote.send(0, 8'h11, 3'b000, 1'b0);
    chk({7'h0, GENERAL_OUTPUT_PIN[4]}, 8'h00);
    chk({7'h0, RX_INT_SOURCE[0]}, 8'h01);
    wr(DUC_ADDR_CMD_A, 8'h10);
    wr(DUC_ADDR_MODE_A, 8'he3);
    wr(DUC_ADDR_CMD_A, 8'h40);
    chk({7'h0, GENERAL_OUTPUT_PIN[4]}, 8'h01);
    chk({7'h0, RX_INT_SOURCE[0]}, 8'h00);
    for (int i = 1; i < 4; i++) begin
      u_duc_remote.send(0, 8'(8'h20 + i), i == 1 ? 3'b001 : 3'b000, 1'b0);
    end
    chk({7'h0, GENERAL_OUTPUT_PIN[4]}, 8'h00);
    chk({7'h0, RX_INT_SOURCE[0]}, 8'h01);
    wr(DUC_ADDR_SET, 8'h01);
    chk({7'h0, GENERAL_OUTPUT_PIN[0]}, 8'h00);
    u_duc_remote.send(0, 8'hee, 3'b000, 1'b1);
    chk({7'h0, GENERAL_OUTPUT_PIN[0]}, 8'h01);
    rd(DUC_ADDR_STAT_A, 8'h13, 8'h13);
    rd(DUC_ADDR_DATA_A, 8'hff, 8'h11);
    chk({7'h0, GENERAL_OUTPUT_PIN[0]}, 8'h00);
    for (int i = 1; i < 4; i++) begin
      rd(DUC_ADDR_DATA_A, 8'hff, 8'(8'h20 + i));
    end
    rd(DUC_ADDR_STAT_A, 8'hf1, 8'h30);
    wr(DUC_ADDR_CMD_A, 8'h40);
    rd(DUC_ADDR_STAT_A, 8'hf0, 8'h00);
    wr(DUC_ADDR_PIN_CFG, 8'h00);
    wr(DUC_ADDR_CLR, 8'hff);
    wr(DUC_ADDR_SET, 8'ha5);
    chk(GENERAL_OUTPUT_PIN, 8'h5a);
    for (int k = 1; k < 4; k++) begin
      wr(DUC_ADDR_PIN_CFG, {4'h0, 2'(k), 2'(k)});
      for (int v = 0; v < 2; v++) begin
        src <= v ? 3'(1 << (k - 1)) : ~3'(1 << (k - 1));
        repeat (3) @(posedge CLK);
        chk({6'h0, GENERAL_OUTPUT_PIN[3:2]}, v ? 8'h03 : 8'h00);
      end
    end
    wr(DUC_ADDR_PIN_CFG, 8'hc0);
    chk({6'h0, GENERAL_OUTPUT_PIN[7:6]}, 8'h02);
    u_duc_remote.set_tx(2'b10);
    chk({6'h0, GENERAL_OUTPUT_PIN[7:6]}, 8'h03);
    wr(DUC_ADDR_CMD_A, 8'h0f);
    chk({6'h0, RX_ENABLED[0], TX_ENABLED[0]}, 8'h00);
    complete_run();
  end
endmodule : duc_tb_top
